// >>> include/pca_pkg.sv
// Shared constants and types for the counter array.
// Assumes an 8-bit special-function-register port on the system clock.
package pca_pkg;
    localparam int NCH = 6;
    // Register indices on the register port
    localparam logic [5:0] ADDR_CNT_LO = 6'h00;
    localparam logic [5:0] ADDR_CNT_HI = 6'h01;
    localparam logic [5:0] ADDR_MODE = 6'h02;
    localparam logic [5:0] ADDR_CTRL = 6'h03;
    localparam logic [5:0] ADDR_PWMCFG = 6'h04;
    localparam logic [5:0] ADDR_CPM_BASE = 6'h08;
    localparam logic [5:0] ADDR_CPL_BASE = 6'h10;
    localparam logic [5:0] ADDR_CPH_BASE = 6'h18;
    // Array mode register fields
    localparam int AM_CIDL = 7;
    localparam int AM_CPS_LO = 1;
    localparam int AM_ECF = 0;
    // Control register fields
    localparam int CT_CF = 7;
    localparam int CT_RUN = 6;
    // Shared PWM configuration fields
    localparam int PC_ARSEL = 7;
    localparam int PC_COVF = 6;
    localparam int PC_ECOV = 5;
    // Module mode control fields
    localparam int MD_PWM16 = 7;
    localparam int MD_ECOM = 6;
    localparam int MD_CAPP = 5;
    localparam int MD_CAPN = 4;
    localparam int MD_MAT = 3;
    localparam int MD_TOG = 2;
    localparam int MD_PWM = 1;
    localparam int MD_ECCF = 0;
    // Timebase encodings
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_T0 = 3'h2;
    localparam logic [2:0] TB_EXTIN = 3'h3;
    localparam logic [2:0] TB_SYS = 3'h4;
    localparam logic [2:0] TB_OSC8 = 3'h5;
    localparam logic [2:0] TB_T4 = 3'h6;
    localparam logic [2:0] TB_T5 = 3'h7;
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_OSC = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // One register port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } pca_sfr_req_t;

    // Low-bit mask of the shared PWM cycle length
    function automatic logic [15:0] len_mask(input logic [1:0] cls);
        case (cls)
            2'h0: len_mask = 16'h00ff;
            2'h1: len_mask = 16'h01ff;
            2'h2: len_mask = 16'h03ff;
            default: len_mask = 16'h07ff;
        endcase
    endfunction : len_mask
endpackage : pca_pkg

// >>> hw/pca_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/100ps
module pca_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : pca_sync

// >>> hw/pca_chan.sv
// One capture/compare module of the counter array.
// Assumes a synchronised pin level and a counter update pulse from the top.
`timescale 1ns/100ps
module pca_chan (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration
    input wire logic [7:0] mode,
    input wire logic [1:0] cls,
    input wire logic arsel,
    // Counter
    input wire logic [15:0] count,
    input wire logic upd,
    // Register writes and pin level
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic io_sync,
    // Results
    output logic [15:0] cp_q,
    output logic [15:0] rl_q,
    output logic io_out,
    output logic io_oe,
    output logic event_pulse
);
    logic lvl_d, lvl_f, lvl_fd;
    logic ecom, capp, capn, mat, tog, pwm, pwm16;
    logic cap_m, swt_m, hso_m, fout_m, pwm_m, short_pwm;
    logic rise, fall, cap_hit, match16, lmatch, wrap, pmatch;
    logic [15:0] mask, eff;

    assign ecom = mode[pca_pkg::MD_ECOM];
    assign capp = mode[pca_pkg::MD_CAPP];
    assign capn = mode[pca_pkg::MD_CAPN];
    assign mat = mode[pca_pkg::MD_MAT];
    assign tog = mode[pca_pkg::MD_TOG];
    assign pwm = mode[pca_pkg::MD_PWM];
    assign pwm16 = mode[pca_pkg::MD_PWM16];

    // Mode decode
    assign cap_m = ~pwm & ~tog & ~mat & (capp | capn);
    assign swt_m = mat & ~tog & ~pwm & ~capp & ~capn;
    assign hso_m = mat & tog & ~pwm;
    assign fout_m = tog & pwm;
    assign pwm_m = pwm & ~tog & ~capp & ~capn;
    assign short_pwm = pwm_m & ~pwm16;

    // Input accepted only after two equal samples
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lvl_d <= 1'b0;
            lvl_f <= 1'b0;
            lvl_fd <= 1'b0;
        end else begin
            lvl_d <= io_sync;
            if (lvl_d == io_sync) begin
                lvl_f <= io_sync;
            end
            lvl_fd <= lvl_f;
        end
    end

    assign rise = lvl_f & ~lvl_fd;
    assign fall = ~lvl_f & lvl_fd;
    assign cap_hit = cap_m & ((rise & capp) | (fall & capn));

    // Comparators, only when the counter has moved
    assign mask = pwm16 ? pca_pkg::CNT_MAX : pca_pkg::len_mask(cls);
    assign match16 = upd & ecom & (count == cp_q);
    assign lmatch = upd & ecom & (count[7:0] == cp_q[7:0]);
    assign wrap = upd & ((count & mask) == 16'h0000);
    assign eff = (short_pwm & wrap) ? ((cls == 2'h0) ? {cp_q[15:8], cp_q[15:8]} : rl_q) : cp_q;
    assign pmatch = upd & ecom & ((count & mask) == (eff & mask));

    // Capture/compare value
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cp_q <= 16'h0000;
        end else if (wr_lo && !arsel) begin
            cp_q[7:0] <= wdata;
        end else if (wr_hi && !arsel) begin
            cp_q[15:8] <= wdata;
        end else if (cap_hit) begin
            cp_q <= count;
        end else if (fout_m && lmatch) begin
            cp_q[7:0] <= cp_q[7:0] + cp_q[15:8];
        end else if (short_pwm && wrap) begin
            cp_q <= eff;
        end
    end

    // Auto-reload value
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rl_q <= 16'h0000;
        end else if (wr_lo && arsel) begin
            rl_q[7:0] <= wdata;
        end else if (wr_hi && arsel) begin
            rl_q[15:8] <= wdata;
        end
    end

    // Pin drive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            io_out <= 1'b0;
            io_oe <= 1'b0;
        end else begin
            io_oe <= pwm | tog;
            if (pwm_m) begin
                if (!ecom) begin
                    io_out <= 1'b0;
                end else if (pmatch) begin
                    io_out <= 1'b1;
                end else if (wrap) begin
                    io_out <= 1'b0;
                end
            end else if ((hso_m && match16) || (fout_m && lmatch)) begin
                io_out <= ~io_out;
            end
        end
    end

    // Channel event
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= cap_hit | ((swt_m | hso_m) & match16) | (fout_m & mat & match16)
                | (pwm_m & mat & pmatch);
        end
    end
endmodule : pca_chan

// >>> hw/pca_top.sv
// Counter array top: counter, timebase, flags, registers and six modules.
// Assumes a single-cycle register port on ref_clk and pulse timer overflows.
`timescale 1ns/100ps
// Behaviour
// - Low-byte read snapshots high byte for later
// - Reads never disturb the counter
// - Three-bit select picks one of eight timebases
// - Oscillator/8 source synchronised before counting
// - Wrap from max to zero sets overflow flag
// - Overflow interrupts only when its enable set
// - Flags stay set until software clears
// - Idle with suspend bit clear keeps counting
// - Intermediate overflow at chosen 8-11 bit length
// - Flags set regardless of any interrupt enable
// - Interrupt is OR of enabled flags
// - Six independent modules each with own line
// - Capture edge choice by mode bits 5,4
// - Timer, high-speed, frequency output encodings
// - Comparator off stops toggles, PWM low
// - PWM by bit 1, bit 7 16-bit
// - Shared two-bit cycle length field
// - One cycle length for all short PWM
// - Reload select bit steers byte accesses
// - Match bit makes PWM matches set flag
// - Per-module and intermediate interrupt enable bits
// - Low write clears, high write sets comparator
// - Capture level must hold two cycles
module pca_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire pca_pkg::pca_sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    // Processor state and timer overflows
    input wire logic cpu_idle,
    input wire logic timer0_ovf,
    input wire logic timer4_ovf,
    input wire logic timer5_ovf,
    // Pins
    input wire logic external_count_input,
    input wire logic ext_osc,
    input wire logic [5:0] module_io_line_in,
    output logic [5:0] module_io_line_out,
    output logic [5:0] module_io_line_oe,
    // Interrupt
    output logic irq_req
);
    localparam int NCH = pca_pkg::NCH;

    logic [15:0] count_reg;
    logic [7:0] snap_reg;
    logic upd_reg;
    logic run_reg, cidl_reg, ecf_reg, arsel_reg, ecov_reg;
    logic [2:0] cps_reg;
    logic [1:0] cls_reg;
    logic cf_reg, covf_reg;
    logic [NCH-1:0] ccf_reg;
    logic [7:0] mode_reg [NCH];
    logic [3:0] div12_reg;
    logic [1:0] div4_reg;
    logic [2:0] osc_div_reg;
    logic ext_prev_reg, osc_prev_reg;
    logic tick_div12, tick_div4, tick_osc, tick_ext;
    logic src, tick, cnt_en;
    logic cf_set, covf_set;
    logic [7:0] pin_sync;
    logic [15:0] cp_val [NCH];
    logic [15:0] rl_val [NCH];
    logic [NCH-1:0] ch_event, wr_lo, wr_hi;
    logic [7:0] rd_next;
    logic [15:0] len;
    logic wr_cnt_lo, wr_cnt_hi, wr_mode, wr_ctrl, wr_pwm;

    // Register write strobes
    assign wr_cnt_lo = sfr.wr && (sfr.addr == pca_pkg::ADDR_CNT_LO);
    assign wr_cnt_hi = sfr.wr && (sfr.addr == pca_pkg::ADDR_CNT_HI);
    assign wr_mode = sfr.wr && (sfr.addr == pca_pkg::ADDR_MODE);
    assign wr_ctrl = sfr.wr && (sfr.addr == pca_pkg::ADDR_CTRL);
    assign wr_pwm = sfr.wr && (sfr.addr == pca_pkg::ADDR_PWMCFG);

    // Pin synchronisers
    pca_sync #(
        .W(8)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d({ext_osc, external_count_input, module_io_line_in}),
        .q(pin_sync)
    );

    // Fixed clock dividers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div12_reg <= 4'h0;
            div4_reg <= 2'h0;
        end else begin
            div12_reg <= (div12_reg == 4'(pca_pkg::DIV_SLOW - 1)) ? 4'h0 : div12_reg + 4'h1;
            div4_reg <= (div4_reg == 2'(pca_pkg::DIV_FAST - 1)) ? 2'h0 : div4_reg + 2'h1;
        end
    end

    assign tick_div12 = (div12_reg == 4'(pca_pkg::DIV_SLOW - 1));
    assign tick_div4 = (div4_reg == 2'(pca_pkg::DIV_FAST - 1));

    // Edge detect of synchronised external sources
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ext_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            osc_div_reg <= 3'h0;
        end else begin
            ext_prev_reg <= pin_sync[6];
            osc_prev_reg <= pin_sync[7];
            if (pin_sync[7] && !osc_prev_reg) begin
                osc_div_reg <= osc_div_reg + 3'h1;
            end
        end
    end

    assign tick_ext = ext_prev_reg && !pin_sync[6];
    assign tick_osc = pin_sync[7] && !osc_prev_reg && (osc_div_reg == 3'(pca_pkg::DIV_OSC - 1));

    // Timebase select
    always_comb begin
        case (cps_reg)
            pca_pkg::TB_DIV12: src = tick_div12;
            pca_pkg::TB_DIV4: src = tick_div4;
            pca_pkg::TB_T0: src = timer0_ovf;
            pca_pkg::TB_EXTIN: src = tick_ext;
            pca_pkg::TB_SYS: src = 1'b1;
            pca_pkg::TB_OSC8: src = tick_osc;
            pca_pkg::TB_T4: src = timer4_ovf;
            default: src = timer5_ovf;
        endcase
    end

    assign cnt_en = run_reg && !(cpu_idle && cidl_reg);
    assign tick = cnt_en && src;
    assign len = pca_pkg::len_mask(cls_reg);
    assign cf_set = tick && (count_reg == pca_pkg::CNT_MAX);
    assign covf_set = tick && ((count_reg & len) == len);

    // Counter; reads have no path here
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_reg <= 16'h0000;
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= tick;
            if (wr_cnt_lo) begin
                count_reg[7:0] <= sfr.wdata;
            end else if (wr_cnt_hi) begin
                count_reg[15:8] <= sfr.wdata;
            end else if (tick) begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end

    // High-byte snapshot on low-byte read
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            snap_reg <= pca_pkg::RESET_BYTE;
        end else if (sfr.rd && sfr.addr == pca_pkg::ADDR_CNT_LO) begin
            snap_reg <= count_reg[15:8];
        end
    end

    // Array mode and shared configuration
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cidl_reg <= 1'b0;
            cps_reg <= 3'h0;
            ecf_reg <= 1'b0;
            arsel_reg <= 1'b0;
            ecov_reg <= 1'b0;
            cls_reg <= 2'h0;
            run_reg <= 1'b0;
        end else begin
            if (wr_mode) begin
                cidl_reg <= sfr.wdata[pca_pkg::AM_CIDL];
                cps_reg <= sfr.wdata[pca_pkg::AM_CPS_LO +: 3];
                ecf_reg <= sfr.wdata[pca_pkg::AM_ECF];
            end
            if (wr_pwm) begin
                arsel_reg <= sfr.wdata[pca_pkg::PC_ARSEL];
                ecov_reg <= sfr.wdata[pca_pkg::PC_ECOV];
                cls_reg <= sfr.wdata[1:0];
            end
            if (wr_ctrl) begin
                run_reg <= sfr.wdata[pca_pkg::CT_RUN];
            end
        end
    end

    // Sticky flags; a hardware set beats a software clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cf_reg <= 1'b0;
            covf_reg <= 1'b0;
            ccf_reg <= '0;
        end else begin
            cf_reg <= (wr_ctrl ? sfr.wdata[pca_pkg::CT_CF] : cf_reg) | cf_set;
            covf_reg <= (wr_pwm ? sfr.wdata[pca_pkg::PC_COVF] : covf_reg) | covf_set;
            ccf_reg <= (wr_ctrl ? sfr.wdata[NCH-1:0] : ccf_reg) | ch_event;
        end
    end

    // Module mode registers with comparator side effects
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                mode_reg[i] <= pca_pkg::RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sfr.wr && sfr.addr == pca_pkg::ADDR_CPM_BASE + 6'(i)) begin
                    mode_reg[i] <= sfr.wdata;
                end else if (wr_lo[i]) begin
                    mode_reg[i][pca_pkg::MD_ECOM] <= 1'b0;
                end else if (wr_hi[i]) begin
                    mode_reg[i][pca_pkg::MD_ECOM] <= 1'b1;
                end
            end
        end
    end

    // Six capture/compare modules
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        assign wr_lo[n] = sfr.wr && (sfr.addr == pca_pkg::ADDR_CPL_BASE + 6'(n));
        assign wr_hi[n] = sfr.wr && (sfr.addr == pca_pkg::ADDR_CPH_BASE + 6'(n));
        pca_chan u_chan (
            .ref_clk(ref_clk),
            .reset(reset),
            .mode(mode_reg[n]),
            .cls(cls_reg),
            .arsel(arsel_reg),
            .count(count_reg),
            .upd(upd_reg),
            .wr_lo(wr_lo[n]),
            .wr_hi(wr_hi[n]),
            .wdata(sfr.wdata),
            .io_sync(pin_sync[n]),
            .cp_q(cp_val[n]),
            .rl_q(rl_val[n]),
            .io_out(module_io_line_out[n]),
            .io_oe(module_io_line_oe[n]),
            .event_pulse(ch_event[n])
        );
    end

    // Read data select
    always_comb begin
        rd_next = pca_pkg::RESET_BYTE;
        if (sfr.addr == pca_pkg::ADDR_CNT_LO) begin
            rd_next = count_reg[7:0];
        end else if (sfr.addr == pca_pkg::ADDR_CNT_HI) begin
            rd_next = snap_reg;
        end else if (sfr.addr == pca_pkg::ADDR_MODE) begin
            rd_next = {cidl_reg, 3'h0, cps_reg, ecf_reg};
        end else if (sfr.addr == pca_pkg::ADDR_CTRL) begin
            rd_next = {cf_reg, run_reg, ccf_reg};
        end else if (sfr.addr == pca_pkg::ADDR_PWMCFG) begin
            rd_next = {arsel_reg, covf_reg, ecov_reg, 3'h0, cls_reg};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sfr.addr == pca_pkg::ADDR_CPM_BASE + 6'(i)) begin
                    rd_next = mode_reg[i];
                end else if (sfr.addr == pca_pkg::ADDR_CPL_BASE + 6'(i)) begin
                    rd_next = arsel_reg ? rl_val[i][7:0] : cp_val[i][7:0];
                end else if (sfr.addr == pca_pkg::ADDR_CPH_BASE + 6'(i)) begin
                    rd_next = arsel_reg ? rl_val[i][15:8] : cp_val[i][15:8];
                end
            end
        end
    end

    // Registered read data, held between reads
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sfr_rdata <= pca_pkg::RESET_BYTE;
        end else if (sfr.rd) begin
            sfr_rdata <= rd_next;
        end
    end

    // Combined interrupt request
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (cf_reg & ecf_reg) | (covf_reg & ecov_reg)
                | (|(ccf_reg & {mode_reg[5][0], mode_reg[4][0], mode_reg[3][0],
                               mode_reg[2][0], mode_reg[1][0], mode_reg[0][0]}));
        end
    end
endmodule : pca_top

// >>> test/pca_monitor.sv
// Port checker for the counter array.
// Assumes binding into pca_top; sees only its ports.
`timescale 1ns/100ps
module pca_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire pca_pkg::pca_sfr_req_t sfr,
    input wire logic [7:0] sfr_rdata,
    // Pins and interrupt
    input wire logic [5:0] module_io_line_out,
    input wire logic [5:0] module_io_line_oe,
    input wire logic irq_req
);
    logic lo_seen;
    // Counter low read seen
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset)
            lo_seen <= 1'b0;
        else if (sfr.rd && sfr.addr == pca_pkg::ADDR_CNT_LO)
            lo_seen <= 1'b1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Register port answers
    rdata_hold_a: assert property (!sfr.rd |=> $stable(sfr_rdata)) else $error("read data moved");
    snap_stale_a: assert property (sfr.rd && sfr.addr == pca_pkg::ADDR_CNT_HI && !lo_seen
        |=> sfr_rdata == 8'h00) else $error("snapshot not stale");
    unmapped_zero_a: assert property (sfr.rd && (sfr.addr inside {[6'h05:6'h07]} || sfr.addr > 6'h1d)
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    mode_reserved_a: assert property (sfr.rd && sfr.addr == pca_pkg::ADDR_MODE
        |=> sfr_rdata[6:4] == 3'h0) else $error("mode reserved bits set");
    pwm_reserved_a: assert property (sfr.rd && sfr.addr == pca_pkg::ADDR_PWMCFG
        |=> sfr_rdata[4:2] == 3'h0) else $error("pwm reserved bits set");
    // Outputs move for a cause
    oe_cause_a: assert property ($changed(module_io_line_oe) |-> $past(sfr.wr) || $past(sfr.wr, 2))
        else $error("oe moved unprompted");
    irq_fall_a: assert property ($fell(irq_req) |-> $past(sfr.wr) || $past(sfr.wr, 2))
        else $error("irq fell unprompted");
    reset_quiet_a: assert property ($fell(reset) |-> irq_req == 1'b0 && module_io_line_oe == 6'h00
        && module_io_line_out == 6'h00 && sfr_rdata == 8'h00) else $error("outputs not quiet at reset");
endmodule : pca_monitor

bind pca_top pca_monitor mon (.ref_clk(ref_clk), .reset(reset), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .module_io_line_out(module_io_line_out), .module_io_line_oe(module_io_line_oe), .irq_req(irq_req));

// >>> test/pca_pins.sv
// Pin model: count input, oscillator, capture lines.
// Assumes pulse is called just after a clock edge.
`timescale 1ns/100ps
module pca_pins (
    // Clock
    input wire logic ref_clk,
    // Pin levels toward the array
    output logic external_count_input,
    output logic ext_osc,
    output logic [5:0] module_io_line_in
);
    // Idle pin levels
    initial begin
        external_count_input = 1'b1;
        ext_osc = 1'b0;
        module_io_line_in = 6'h00;
    end
    // Free oscillator, 20 ns period
    always #10 ext_osc = ~ext_osc;
    // Count input toggles every 4 clocks
    always begin
        repeat (4) @(posedge ref_clk);
        #1 external_count_input = ~external_count_input;
    end
    // Holds one capture line high for len clocks
    task automatic pulse(input int n, input int len);
        @(posedge ref_clk);
        #1 module_io_line_in[n] = 1'b1;
        repeat (len) @(posedge ref_clk);
        #1 module_io_line_in[n] = 1'b0;
    endtask : pulse
endmodule : pca_pins

// >>> test/tb_top.sv
// Self-checking bench for the counter array.
// Assumes the pin model and the bound checker.
`timescale 1ns/100ps
module tb_top;
    localparam int K = 240;
    localparam logic [5:0] A_LO = pca_pkg::ADDR_CNT_LO, A_HI = pca_pkg::ADDR_CNT_HI;
    localparam logic [5:0] A_MD = pca_pkg::ADDR_MODE, A_CT = pca_pkg::ADDR_CTRL, A_PW = pca_pkg::ADDR_PWMCFG;
    localparam logic [5:0] A_CM = pca_pkg::ADDR_CPM_BASE, A_CL = pca_pkg::ADDR_CPL_BASE, A_CH = pca_pkg::ADDR_CPH_BASE;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    pca_pkg::pca_sfr_req_t sfr = '0;
    logic cpu_idle = 1'b0;
    logic [2:0] tov = 3'h0;
    logic external_count_pin, osc, irq_req;
    logic [5:0] io_in, io_out, io_oe;
    logic [7:0] rdata;
    logic [15:0] cv;
    int fails = 0, n_checks = 0, cyc = 0;
    int dv[8] = '{pca_pkg::DIV_SLOW, pca_pkg::DIV_FAST, 5, 8, 1, 20, 6, 7};

    // Design and pin model
    pca_top dut (.ref_clk(ref_clk), .reset(reset), .sfr(sfr), .sfr_rdata(rdata), .cpu_idle(cpu_idle),
        .timer0_ovf(tov[0]), .timer4_ovf(tov[1]), .timer5_ovf(tov[2]), .external_count_input(external_count_pin),
        .ext_osc(osc), .module_io_line_in(io_in), .module_io_line_out(io_out), .module_io_line_oe(io_oe),
        .irq_req(irq_req));
    pca_pins pins (.ref_clk(ref_clk), .external_count_input(external_count_pin), .ext_osc(osc), .module_io_line_in(io_in));

    // Clock, 8 ns period
    always #4 ref_clk = ~ref_clk;
    // Timer overflow pulses every 5, 6 and 7 clocks
    always @(posedge ref_clk) begin
        #1 cyc = cyc + 1;
        tov = {(cyc % 7 == 0), (cyc % 6 == 0), (cyc % 5 == 0)};
    end

    // Register port access
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        sfr = '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        #1 d = rdata;
    endtask : rd
    task automatic idle(input int n);
        sfr = '0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    // Comparisons
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic rng(input string s, input int lo, input int hi, input logic [15:0] g);
        n_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            fails++;
            $display("[FAIL] %s exp %0d..%0d got %0d", s, lo, hi, g);
        end
    endtask : rng
    task automatic rc(input logic [5:0] a, input logic [7:0] e, input string s);
        logic [7:0] d;
        rd(a, d);
        chk(s, 16'(e), 16'(d));
    endtask : rc
    // Counter as two bytes
    task automatic setc(input logic [15:0] v);
        wr(A_LO, v[7:0]);
        wr(A_HI, v[15:8]);
    endtask : setc
    task automatic cnt(output logic [15:0] v);
        rd(A_LO, v[7:0]);
        rd(A_HI, v[15:8]);
    endtask : cnt
    // K clocks on one timebase, read mid-run
    task automatic run(input logic [2:0] s, input logic i, input logic p, input int e, input int t);
        logic [15:0] c;
        wr(A_CT, 8'h00);
        setc(16'h0000);
        wr(A_MD, {p, 3'h0, s, 1'b0});
        cpu_idle = i;
        wr(A_CT, 8'h40);
        cnt(c);
        idle(K - 3);
        wr(A_CT, 8'h00);
        cpu_idle = 1'b0;
        cnt(c);
        rng("count", e - t, e + t, c);
    endtask : run
    // Intermediate flag, one length
    task automatic ovr(input logic [1:0] c, input logic [15:0] st, input logic f);
        wr(A_CT, 8'h00);
        wr(A_PW, {6'h00, c});
        setc(st);
        wr(A_CT, 8'h40);
        idle(4);
        rc(A_PW, {1'b0, f, 4'h0, c}, "mid flag");
    endtask : ovr
    // Verdict
    task automatic close_out();
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 reset = 1'b0;
        // Snapshot of the high byte
        setc(16'h3456);
        rc(A_HI, 8'h00, "stale hi");
        rc(A_LO, 8'h56, "cnt lo");
        rc(A_HI, 8'h34, "snap hi");
        wr(A_HI, 8'h77);
        rc(A_HI, 8'h34, "held snap");
        // Reset values and unmapped slots
        wr(6'h05, 8'hff);
        for (int a = 2; a < 32; a++) rc(6'(a), 8'h00, "reset reg");
        // Timebases, then idle
        for (int s = 0; s < 8; s++) run(3'(s), 1'b0, 1'b0, K / dv[s], dv[s] > 1);
        run(pca_pkg::TB_SYS, 1'b1, 1'b0, K, 0);
        run(pca_pkg::TB_SYS, 1'b1, 1'b1, 0, 0);
        // Wrap flag, enable, clearing
        wr(A_MD, {4'h0, pca_pkg::TB_SYS, 1'b0});
        setc(16'hfffe);
        wr(A_CT, 8'h40);
        idle(4);
        rc(A_CT, 8'hc0, "wrap flag");
        chk("irq off", 16'h0, 16'(irq_req));
        wr(A_MD, {4'h0, pca_pkg::TB_SYS, 1'b1});
        idle(6);
        rc(A_CT, 8'hc0, "flag kept");
        chk("irq on", 16'h1, 16'(irq_req));
        wr(A_CT, 8'h40);
        idle(1);
        chk("irq clear", 16'h0, 16'(irq_req));
        // Intermediate overflow per length
        for (int c = 0; c < 4; c++) begin
            ovr(2'(c), (16'h0001 << (8 + c)) - 16'h0002, 1'b1);
            ovr(2'(c), (16'h0001 << (7 + c)) - 16'h0002, 1'b0);
        end
        // Software timers, compare 16 << n
        wr(A_PW, 8'h00);
        wr(A_MD, {4'h0, pca_pkg::TB_SYS, 1'b0});
        for (int n = 0; n < 6; n++) begin
            cv = 16'h0010 << n;
            wr(A_CM + 6'(n), 8'h49);
            wr(A_CL + 6'(n), cv[7:0]);
            rc(A_CM + 6'(n), 8'h09, "low clears");
            wr(A_CH + 6'(n), cv[15:8]);
            rc(A_CM + 6'(n), 8'h49, "high sets");
        end
        setc(16'h0000);
        wr(A_CT, 8'h40);
        idle(100);
        rc(A_CT, 8'h47, "chan flags");
        chk("chan irq", 16'h1, 16'(irq_req));
        // Output modes, comparator off/on
        wr(A_CM + 6'h3, 8'h0c);
        wr(A_CM + 6'h4, 8'h4c);
        wr(A_CM + 6'h5, 8'h02);
        for (int i = 0; i < 200; i++) begin
            idle(1);
            chk("off pins", 16'h0, {14'h0, io_out[5], io_out[3]});
        end
        chk("hso pin", 16'h1, 16'(io_out[4]));
        chk("pin oe", 16'h0038, {10'h0, io_oe});
        // Capture edges and pulse length
        wr(A_CM, 8'h20);
        wr(A_CM + 6'h1, 8'h10);
        wr(A_CT, 8'h40);
        idle(1);
        pins.pulse(0, 1);
        idle(8);
        rc(A_CT, 8'h40, "short pulse");
        idle(1);
        pins.pulse(0, 3);
        idle(8);
        rc(A_CT, 8'h41, "rise capture");
        idle(1);
        pins.pulse(1, 3);
        idle(8);
        rc(A_CT, 8'h43, "fall capture");
        // Reload select steering
        wr(A_PW, 8'h80);
        wr(A_CL + 6'h2, 8'haa);
        rc(A_CL + 6'h2, 8'haa, "reload reg");
        wr(A_PW, 8'h00);
        rc(A_CL + 6'h2, 8'h40, "compare reg");
        idle(2);
        close_out();
    end
endmodule : tb_top
